// file: core/rwc_pkg.sv
// constants, modes and layouts for the remote word command handler
// assumes a single 25 MHz clock domain and synchronous master-side inputs
package rwc_pkg;
	localparam int         WORD_W        = 16;
	localparam int         SLOT_N        = 6;
	localparam int         SLOT_W        = 3;
	localparam int         QUAD_N        = 4;
	localparam logic [WORD_W-1:0] SKIP_CODE     = 16'hFFFF;
	localparam logic [WORD_W-1:0] SP_MAX        = 16'h2710;
	localparam logic signed [WORD_W-1:0] DEV_MAX = 16'sh2710;
	localparam logic signed [WORD_W-1:0] DEV_MIN = -16'sh2710;
	localparam logic [WORD_W-1:0] QUAD_MAX      = 16'h9C40;
	localparam logic [WORD_W-1:0] TORQ_RESET    = 16'h0000;
	localparam logic [WORD_W-1:0] QUAD_RESET    = 16'h0000;
	localparam logic [7:0] PID_SEL_A     = 8'h32;
	localparam logic [7:0] PID_SEL_B     = 8'h33;
	localparam logic [7:0] PID_SEL_C     = 8'h3C;
	localparam logic [7:0] PID_SEL_D     = 8'h3D;
	localparam logic [7:0] EXT_14        = 8'h0E;
	localparam logic [7:0] EXT_18        = 8'h12;
	localparam logic [7:0] EXT_24        = 8'h18;
	localparam logic [7:0] EXT_28        = 8'h1C;
	localparam logic [3:0] TSRC_3        = 4'h3;
	localparam logic [3:0] TSRC_5        = 4'h5;
	localparam logic [3:0] TLIM_WORD     = 4'h2;
	localparam int         EXT_HI        = 15;
	localparam int         EXT_LO        = 8;
	localparam int         CODE_HI       = 7;
	localparam logic [7:0] REPLY_OK      = 8'h00;
	localparam logic [7:0] REPLY_FAULT   = 8'h01;
	typedef enum logic [1:0] {
		CTRL_SPEED,
		CTRL_TORQUE,
		CTRL_POSITION
	} ctrl_mode_e;
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ISSUE,
		SEQ_WAIT,
		SEQ_DONE
	} seq_state_e;
endpackage : rwc_pkg

// file: core/rwc_slot_picker.sv
// picks the next instruction slot to run after a given one
// assumes slot 0 is the base slot and is never skipped
`timescale 1ns/1ps
module rwc_slot_picker (
	input  wire logic [rwc_pkg::SLOT_W-1:0] curSlot,
	input  wire logic [rwc_pkg::SLOT_N-1:0] slotLive,
	output logic                            hasNext,
	output logic [rwc_pkg::SLOT_W-1:0]      nextSlot
);
	import rwc_pkg::*;

	// lowest live slot above curSlot; fixed ascending order
	always_comb begin
		hasNext  = 1'b0;
		nextSlot = curSlot;
		for (int i = SLOT_N - 1; i > 0; i--) begin
			if (slotLive[i] && (i > int'(curSlot))) begin
				hasNext  = 1'b1;
				nextSlot = SLOT_W'(i);
			end
		end
	end
endmodule : rwc_slot_picker

// file: core/remote_word_command_handler.sv
// remote word interpreter: pid words, torque command and limits, chained instructions
// assumes master words and request bits are synchronous to ref_clk; executor answers one slot at a time
`timescale 1ns/1ps

// Functional notes
// - set point word is percent times 100, 0..10000 accepted.
// - deviation word accepted signed from -10000 to +10000.
// - pid words held only when pid action selection is 50, 51, 60, 61.
// - shared word is torque command for ext 14/18/24/28, source 3/5, torque control.
// - torque words applied on ram or eeprom request; both params updated together.
// - ext 14/18, source 3/5, limit method 2, speed/position: single limit taken.
// - ext 24/28, method 2: four quadrant limits, 0..40000 each.
// - quadrant limits taken on ram request only, never on eeprom request.
// - quadrant 2..4 word of FFFF uses the first-quadrant limit.
// - valid first-quadrant word with source 3/5 updates both torque params.
// - execute runs base slot then 10,12,14,16,18; done after last completes.
// - extra slot code FFFF skips it; base slot always runs.
// - upper 8 bits of extra code are link extended setting, rest instruction.
// - each extra code pairs with following write data word.
// - signed frequency selection 1 makes frequency word signed, negative reverses.
// - reply code per executed slot, zero normal, nonzero fault.
module remote_word_command_handler (
	input  wire logic                        ref_clk,
	input  wire logic                        arst_n,
	input  wire logic [rwc_pkg::WORD_W-1:0]  pidSetPoint,
	input  wire logic [rwc_pkg::WORD_W-1:0]  pidMeasuredValue,
	input  wire logic [rwc_pkg::WORD_W-1:0]  pidDeviationOrTorqueCommand,
	input  wire logic [rwc_pkg::WORD_W-1:0]  torqueLimitFirstQuadrant,
	input  wire logic [rwc_pkg::WORD_W-1:0]  torqueLimitSecondQuadrant,
	input  wire logic [rwc_pkg::WORD_W-1:0]  torqueLimitThirdQuadrant,
	input  wire logic [rwc_pkg::WORD_W-1:0]  torqueLimitFourthQuadrant,
	input  wire logic [rwc_pkg::WORD_W-1:0]  baseInstructionSlot,
	input  wire logic [rwc_pkg::WORD_W-1:0]  baseWriteData,
	input  wire logic [5*rwc_pkg::WORD_W-1:0] extraInstructionCodes,
	input  wire logic [5*rwc_pkg::WORD_W-1:0] extraInstructionWriteData,
	input  wire logic [rwc_pkg::WORD_W-1:0]  setFrequency,
	input  wire logic                        ram_write_request,
	input  wire logic                        eeprom_write_request,
	input  wire logic                        instruction_execute_request,
	input  wire logic [7:0]                  extended_setting_selection,
	input  wire logic [3:0]                  torque_source_selection,
	input  wire logic [3:0]                  torque_limit_input_method,
	input  wire logic [7:0]                  pid_action_selection,
	input  wire logic                        signed_frequency_selection,
	input  wire rwc_pkg::ctrl_mode_e         controlMode,
	input  wire logic [rwc_pkg::WORD_W-1:0]  torqueParamMax,
	input  wire logic                        execDone,
	input  wire logic [7:0]                  execReply,
	input  wire logic [rwc_pkg::WORD_W-1:0]  execReadData,
	output logic                             execStart,
	output logic [7:0]                       execLinkExt,
	output logic [7:0]                       execCode,
	output logic [rwc_pkg::WORD_W-1:0]       execWriteData,
	output logic [rwc_pkg::SLOT_W-1:0]       execSlot,
	output logic                             instruction_done_flag,
	output logic [rwc_pkg::SLOT_N*8-1:0]     replyCodes,
	output logic [rwc_pkg::SLOT_N*rwc_pkg::WORD_W-1:0] replyReadData,
	output logic [rwc_pkg::WORD_W-1:0]       heldPidSetPoint,
	output logic [rwc_pkg::WORD_W-1:0]       heldPidMeasured,
	output logic [rwc_pkg::WORD_W-1:0]       heldPidDeviation,
	output logic [rwc_pkg::WORD_W-1:0]       torque_value_ram_param,
	output logic [rwc_pkg::WORD_W-1:0]       torque_value_ram_eeprom_param,
	output logic [rwc_pkg::QUAD_N*rwc_pkg::WORD_W-1:0] quadrantLimits,
	output logic [rwc_pkg::WORD_W-1:0]       freqMagnitude,
	output logic                             freqReverse,
	output logic                             torqueWriteReply
);
	import rwc_pkg::*;

	typedef struct packed {
		seq_state_e                 seq;
		logic [SLOT_W-1:0]          slot;
		logic                       start;
		logic                       done;
		logic [7:0]                 linkExt;
		logic [7:0]                 code;
		logic [WORD_W-1:0]          wdata;
		logic [SLOT_N*8-1:0]        replies;
		logic [SLOT_N*WORD_W-1:0]   rdata;
		logic [WORD_W-1:0]          sp;
		logic [WORD_W-1:0]          pv;
		logic [WORD_W-1:0]          dev;
		logic [WORD_W-1:0]          tqRam;
		logic [WORD_W-1:0]          tqRamEe;
		logic [QUAD_N*WORD_W-1:0]   quad;
		logic [WORD_W-1:0]          fMag;
		logic                       fRev;
		logic                       tqReply;
		logic                       wrReqPrev;
	} state_s;

	state_s cur_ff;
	state_s nxt_cur;

	logic [SLOT_N*WORD_W-1:0] slotCodes;
	logic [SLOT_N*WORD_W-1:0] slotData;
	logic [SLOT_N-1:0]        slotLive;
	logic                     hasNext;
	logic [SLOT_W-1:0]        nextSlot;

	// slot 0 is the base pair; slots 1..5 are the extra pairs in order
	assign slotCodes = {extraInstructionCodes, baseInstructionSlot};
	assign slotData  = {extraInstructionWriteData, baseWriteData};

	genvar g;
	generate
		for (g = 0; g < SLOT_N; g++) begin : g_live
			if (g == 0) begin : g_base
				assign slotLive[g] = 1'b1;
			end else begin : g_extra
				assign slotLive[g] = (slotCodes[g*WORD_W +: WORD_W] != SKIP_CODE);
			end
		end
	endgenerate

	rwc_slot_picker u_picker (
		.curSlot  (cur_ff.slot),
		.slotLive (slotLive),
		.hasNext  (hasNext),
		.nextSlot (nextSlot)
	);

	logic pidOn;
	logic srcOk;
	logic singleMode;
	logic quadMode;
	logic tqCmdMode;
	logic wrReq;
	logic wrRise;
	logic ramRise;
	logic signed [WORD_W-1:0] devS;
	logic signed [WORD_W-1:0] fS;
	logic [WORD_W-1:0]        q1;
	logic [WORD_W-1:0]        qw;
	logic [WORD_W-1:0]        tqWord;

	always_comb begin
		pidOn = (pid_action_selection == PID_SEL_A) || (pid_action_selection == PID_SEL_B) ||
			(pid_action_selection == PID_SEL_C) || (pid_action_selection == PID_SEL_D);
		srcOk = (torque_source_selection == TSRC_3) || (torque_source_selection == TSRC_5);
		tqCmdMode = ((extended_setting_selection == EXT_14) || (extended_setting_selection == EXT_18) ||
			(extended_setting_selection == EXT_24) || (extended_setting_selection == EXT_28)) &&
			srcOk && (controlMode == CTRL_TORQUE);
		singleMode = ((extended_setting_selection == EXT_14) || (extended_setting_selection == EXT_18)) &&
			srcOk && (torque_limit_input_method == TLIM_WORD) && (controlMode != CTRL_TORQUE);
		quadMode = ((extended_setting_selection == EXT_24) || (extended_setting_selection == EXT_28)) &&
			(torque_limit_input_method == TLIM_WORD) && (controlMode != CTRL_TORQUE);
		wrReq   = ram_write_request || eeprom_write_request;
		// edge-triggered so a held request applies once
		wrRise  = wrReq && !cur_ff.wrReqPrev;
		ramRise = wrRise && ram_write_request;
		devS = $signed(pidDeviationOrTorqueCommand);
		fS   = $signed(setFrequency);
		q1   = torqueLimitFirstQuadrant;
		qw   = '0;
		tqWord = '0;

		nxt_cur = cur_ff;
		nxt_cur.start     = 1'b0;
		nxt_cur.tqReply   = 1'b0;
		nxt_cur.wrReqPrev = wrReq;

		// pid words: out-of-range or disabled keeps the held value
		if (pidOn) begin
			if (pidSetPoint <= SP_MAX)
				nxt_cur.sp = pidSetPoint;
			if (pidMeasuredValue <= SP_MAX)
				nxt_cur.pv = pidMeasuredValue;
			if (!tqCmdMode && (devS >= DEV_MIN) && (devS <= DEV_MAX))
				nxt_cur.dev = pidDeviationOrTorqueCommand;
		end

		// torque command or single limit; torque range given by the drive
		if (wrRise && (tqCmdMode || singleMode)) begin
			tqWord = tqCmdMode ? pidDeviationOrTorqueCommand : torqueLimitFirstQuadrant;
			if (tqWord <= torqueParamMax) begin
				nxt_cur.tqRam   = tqWord;
				nxt_cur.tqRamEe = tqWord;
				nxt_cur.tqReply = 1'b1;
			end
		end

		// quadrant limits: ram request only
		if (ramRise && quadMode && (q1 <= QUAD_MAX)) begin
			nxt_cur.quad[0 +: WORD_W] = q1;
			for (int i = 1; i < QUAD_N; i++) begin
				qw = (i == 1) ? torqueLimitSecondQuadrant :
					(i == 2) ? torqueLimitThirdQuadrant : torqueLimitFourthQuadrant;
				if (qw == SKIP_CODE)
					nxt_cur.quad[i*WORD_W +: WORD_W] = q1;
				else if (qw <= QUAD_MAX)
					nxt_cur.quad[i*WORD_W +: WORD_W] = qw;
			end
			if (srcOk && (q1 <= torqueParamMax)) begin
				nxt_cur.tqRam   = q1;
				nxt_cur.tqRamEe = q1;
			end
			nxt_cur.tqReply = 1'b1;
		end

		// frequency word sign handling
		if (signed_frequency_selection && fS[WORD_W-1]) begin
			nxt_cur.fMag = WORD_W'(-fS);
			nxt_cur.fRev = 1'b1;
		end else begin
			nxt_cur.fMag = setFrequency;
			nxt_cur.fRev = 1'b0;
		end

		// instruction chain sequencer
		case (cur_ff.seq)
			SEQ_IDLE: begin
				// master has loaded all pairs before raising execute
				if (instruction_execute_request) begin
					nxt_cur.slot    = '0;
					nxt_cur.seq     = SEQ_ISSUE;
					nxt_cur.replies = '0;
				end
			end
			SEQ_ISSUE: begin
				nxt_cur.linkExt = slotCodes[int'(cur_ff.slot)*WORD_W + EXT_LO +: 8];
				nxt_cur.code    = slotCodes[int'(cur_ff.slot)*WORD_W +: CODE_HI + 1];
				nxt_cur.wdata   = slotData[int'(cur_ff.slot)*WORD_W +: WORD_W];
				nxt_cur.start   = 1'b1;
				nxt_cur.seq     = SEQ_WAIT;
			end
			SEQ_WAIT: begin
				if (execDone) begin
					nxt_cur.replies[int'(cur_ff.slot)*8 +: 8] = execReply;
					if (execReply == REPLY_OK)
						nxt_cur.rdata[int'(cur_ff.slot)*WORD_W +: WORD_W] = execReadData;
					if (hasNext) begin
						nxt_cur.slot = nextSlot;
						nxt_cur.seq  = SEQ_ISSUE;
					end else begin
						nxt_cur.done = 1'b1;
						nxt_cur.seq  = SEQ_DONE;
					end
				end
			end
			SEQ_DONE: begin
				if (!instruction_execute_request) begin
					nxt_cur.done = 1'b0;
					nxt_cur.seq  = SEQ_IDLE;
				end
			end
			default: nxt_cur.seq = SEQ_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_ff         <= '0;
			cur_ff.seq     <= SEQ_IDLE;
			cur_ff.tqRam   <= TORQ_RESET;
			cur_ff.tqRamEe <= TORQ_RESET;
			cur_ff.quad    <= {QUAD_N{QUAD_RESET}};
			cur_ff.replies <= {SLOT_N{REPLY_OK}};
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign execStart                     = cur_ff.start;
	assign execLinkExt                   = cur_ff.linkExt;
	assign execCode                      = cur_ff.code;
	assign execWriteData                 = cur_ff.wdata;
	assign execSlot                      = cur_ff.slot;
	assign instruction_done_flag         = cur_ff.done;
	assign replyCodes                    = cur_ff.replies;
	assign replyReadData                 = cur_ff.rdata;
	assign heldPidSetPoint               = cur_ff.sp;
	assign heldPidMeasured               = cur_ff.pv;
	assign heldPidDeviation              = cur_ff.dev;
	assign torque_value_ram_param        = cur_ff.tqRam;
	assign torque_value_ram_eeprom_param = cur_ff.tqRamEe;
	assign quadrantLimits                = cur_ff.quad;
	assign freqMagnitude                 = cur_ff.fMag;
	assign freqReverse                   = cur_ff.fRev;
	assign torqueWriteReply              = cur_ff.tqReply;
endmodule : remote_word_command_handler

// file: sim/rwc_executor.sv
// behavioural executor that answers one issued instruction slot at a time
// assumes execStart pulses once per slot; latency is set by the bench
`timescale 1ns/1ps
module rwc_executor (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        execStart,
	input  wire logic [15:0] execWriteData,
	input  wire logic [3:0]  lat,
	output logic             execDone,
	output logic [7:0]       execReply,
	output logic [15:0]      execReadData
);
	logic [3:0]  cnt;
	logic        busy;
	logic [15:0] dat;
	logic [7:0]  junk;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			{busy, cnt, execDone, dat, junk} <= '0;
		end else begin
			junk <= junk + 8'h5B;
			execDone <= 1'b0;
			if (execStart) begin
				busy <= 1'b1;
				cnt <= lat;
				dat <= execWriteData;
			end else if (busy && cnt == 4'h0) begin
				busy <= 1'b0;
				execDone <= 1'b1;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
	// nonzero reply for data with top bit set; junk outside done so stale values never pass
	assign execReply = execDone ? {7'h00, dat[15]} : junk;
	assign execReadData = execDone ? ~dat : {junk, junk};
endmodule : rwc_executor

// file: sim/remote_word_command_handler_asserts.sv
// temporal checks on the handler ports
// assumes one clock domain, bound onto every handler instance
`timescale 1ns/1ps
module rwc_checker (
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic        execStart,
	input wire logic        execDone,
	input wire logic [2:0]  execSlot,
	input wire logic [7:0]  execLinkExt,
	input wire logic [7:0]  execCode,
	input wire logic [15:0] execWriteData,
	input wire logic [79:0] extraInstructionCodes,
	input wire logic [79:0] extraInstructionWriteData,
	input wire logic        instruction_execute_request,
	input wire logic        instruction_done_flag,
	input wire logic        ram_write_request,
	input wire logic        eeprom_write_request,
	input wire logic        torqueWriteReply,
	input wire logic [15:0] torque_value_ram_param,
	input wire logic [15:0] torque_value_ram_eeprom_param,
	input wire logic [63:0] quadrantLimits,
	input wire logic [15:0] heldPidSetPoint,
	input wire logic [15:0] heldPidDeviation,
	input wire logic [7:0]  pid_action_selection,
	input wire logic        freqReverse,
	input wire logic        signed_frequency_selection
);
	import rwc_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	logic [2:0] idx;
	logic       anyReq;
	logic       pidOk;
	assign idx = execSlot - 3'd1;
	assign anyReq = ram_write_request | eeprom_write_request;
	assign pidOk = pid_action_selection inside {PID_SEL_A, PID_SEL_B, PID_SEL_C, PID_SEL_D};
	AST_START_PULSE: assert property (execStart |=> !execStart) else $error("start longer than one cycle");
	AST_DONE_AFTER_LAST: assert property ($rose(instruction_done_flag) |-> $past(execDone))
		else $error("done without last slot answer");
	AST_DONE_CLEAR: assert property (!instruction_execute_request && instruction_done_flag |-> ##[1:2]
		!instruction_done_flag) else $error("done stuck after request low");
	AST_TORQ_TWIN: assert property (torque_value_ram_param == torque_value_ram_eeprom_param)
		else $error("torque params differ");
	AST_TORQ_CAUSE: assert property ($changed(torque_value_ram_param) |->
		$past(anyReq) || $past(anyReq, 2)) else $error("torque param moved without request");
	AST_QUAD_RAM: assert property ($changed(quadrantLimits) |-> $past(ram_write_request) ||
		$past(ram_write_request, 2)) else $error("quadrant limits moved without ram request");
	AST_QUAD_MAX: assert property (quadrantLimits[15:0] <= QUAD_MAX &&
		quadrantLimits[31:16] <= QUAD_MAX && quadrantLimits[47:32] <= QUAD_MAX && quadrantLimits[63:48] <= QUAD_MAX)
		else $error("quadrant over range");
	AST_PID_GATE: assert property ($changed(heldPidSetPoint) |-> heldPidSetPoint <= SP_MAX &&
		($past(pidOk) || $past(pidOk, 2))) else $error("set point taken while disabled or out of range");
	AST_DEV_RANGE: assert property ($signed(heldPidDeviation) >= DEV_MIN &&
		$signed(heldPidDeviation) <= DEV_MAX) else $error("deviation out of range");
	AST_SLOT_PAIR: assert property (execStart && execSlot != 3'd0 |->
		extraInstructionCodes[16*idx +: 16] != SKIP_CODE
		&& {execLinkExt, execCode} == extraInstructionCodes[16*idx +: 16]
		&& execWriteData == extraInstructionWriteData[16*idx +: 16]) else $error("slot fields wrong");
	AST_FREQ_SIGN: assert property (freqReverse |-> $past(signed_frequency_selection))
		else $error("reverse while unsigned");
	AST_REPLY_PULSE: assert property (torqueWriteReply |=> !torqueWriteReply) else $error("torque reply held");
	cover property ($rose(instruction_done_flag));
	cover property ($changed(quadrantLimits));
	cover property (freqReverse);
endmodule : rwc_checker
bind remote_word_command_handler rwc_checker rwc_checker_inst (.ref_clk, .arst_n, .execStart, .execDone, .execSlot,
	.execLinkExt, .execCode, .execWriteData, .extraInstructionCodes, .extraInstructionWriteData,
	.instruction_execute_request, .instruction_done_flag, .ram_write_request, .eeprom_write_request,
	.torqueWriteReply, .torque_value_ram_param, .torque_value_ram_eeprom_param, .quadrantLimits,
	.heldPidSetPoint, .heldPidDeviation, .pid_action_selection, .freqReverse, .signed_frequency_selection);

// file: sim/test_remote_word_command_handler.sv
// self-checking bench for the remote word command handler
// assumes the executor model and the bound checker are compiled alongside
`timescale 1ns/1ps
module test_remote_word_command_handler;
	import rwc_pkg::*;
	`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin nErrors++; \
		$display("Error %s expected %0h seen %0h", nm, e, g); end end
	logic ref_clk, arst_n, ram_write_request, eeprom_write_request, instruction_execute_request, execDone;
	logic signed_frequency_selection, execStart, instruction_done_flag, freqReverse, torqueWriteReply, rep;
	logic [15:0] pidSetPoint, pidMeasuredValue, pidDeviationOrTorqueCommand, torqueLimitFirstQuadrant;
	logic [15:0] torqueLimitSecondQuadrant, torqueLimitThirdQuadrant, torqueLimitFourthQuadrant, baseInstructionSlot;
	logic [15:0] baseWriteData, setFrequency, torqueParamMax, execReadData, execWriteData, heldPidSetPoint;
	logic [15:0] heldPidMeasured, heldPidDeviation, torque_value_ram_param, torque_value_ram_eeprom_param;
	logic [15:0] freqMagnitude, c, dw, fw, q3, q4;
	logic [79:0] extraInstructionCodes, extraInstructionWriteData;
	logic [7:0]  extended_setting_selection, pid_action_selection, execReply, execLinkExt, execCode;
	logic [3:0]  torque_source_selection, torque_limit_input_method, lat;
	logic [2:0]  execSlot;
	logic [47:0] replyCodes;
	logic [95:0] replyReadData;
	logic [63:0] quadrantLimits, ql;
	ctrl_mode_e  controlMode;
	int w, d, sp, dev, tq, s, neg, cycles, nErrors, nTests;
	int expSlots[$], seen[$];
	logic [7:0] sels[5] = '{PID_SEL_A, PID_SEL_B, PID_SEL_C, PID_SEL_D, 8'h00};
	logic [7:0] exts[4] = '{EXT_14, EXT_18, EXT_24, EXT_28};
	remote_word_command_handler remote_word_command_handler_inst (.ref_clk, .arst_n, .pidSetPoint,
		.pidMeasuredValue, .pidDeviationOrTorqueCommand, .torqueLimitFirstQuadrant, .torqueLimitSecondQuadrant,
		.torqueLimitThirdQuadrant, .torqueLimitFourthQuadrant, .baseInstructionSlot, .baseWriteData,
		.extraInstructionCodes, .extraInstructionWriteData, .setFrequency, .ram_write_request, .eeprom_write_request,
		.instruction_execute_request, .extended_setting_selection, .torque_source_selection,
		.torque_limit_input_method, .pid_action_selection, .signed_frequency_selection, .controlMode,
		.torqueParamMax, .execDone, .execReply, .execReadData, .execStart, .execLinkExt, .execCode, .execWriteData,
		.execSlot, .instruction_done_flag, .replyCodes, .replyReadData, .heldPidSetPoint, .heldPidMeasured,
		.heldPidDeviation, .torque_value_ram_param, .torque_value_ram_eeprom_param, .quadrantLimits,
		.freqMagnitude, .freqReverse, .torqueWriteReply);
	rwc_executor rwc_executor_inst (.ref_clk, .arst_n, .execStart, .execWriteData, .lat, .execDone, .execReply,
		.execReadData);
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (execStart === 1'b1) seen.push_back(int'(execSlot));
		cycles++;
		if (cycles == 20000) begin
			nErrors++;
			conclude();
		end
	end
	task tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	// one-cycle request then low; the handler only acts on the rising request
	task torqWrite(input bit ram);
		if (ram) ram_write_request = 1'b1;
		else eeprom_write_request = 1'b1;
		tick(1);
		rep = torqueWriteReply;
		{ram_write_request, eeprom_write_request} = 2'b00;
		tick(2);
	endtask : torqWrite
	task conclude;
		if (nErrors == 0 && nTests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : conclude
	initial begin
		{ref_clk, arst_n, lat, ql, sp, dev, tq} = '0;
		controlMode = CTRL_SPEED;
		{pidSetPoint, pidMeasuredValue, pidDeviationOrTorqueCommand, torqueLimitFirstQuadrant, baseInstructionSlot,
			torqueLimitSecondQuadrant, torqueLimitThirdQuadrant, torqueLimitFourthQuadrant, baseWriteData,
			extraInstructionCodes, extraInstructionWriteData, setFrequency, ram_write_request, eeprom_write_request,
			instruction_execute_request, extended_setting_selection, torque_source_selection, torqueParamMax,
			torque_limit_input_method, pid_action_selection, signed_frequency_selection} = '0;
		void'($urandom(32'hDC246811));
		tick(10);
		arst_n = 1'b1;
		tick(1);
		for (int i = 0; i < 10; i++) begin
			w = i == 3 ? 10001 : i == 4 ? 10000 : $urandom_range(10000);
			d = i == 5 ? -10001 : i == 6 ? -10000 : i == 7 ? 10001 : int'($urandom_range(20000)) - 10000;
			pid_action_selection = sels[i%5];
			{pidSetPoint, pidMeasuredValue, pidDeviationOrTorqueCommand} = {w[15:0], w[15:0], d[15:0]};
			tick(2);
			if (i % 5 != 4 && w <= 10000) sp = w;
			if (i % 5 != 4 && d >= -10000 && d <= 10000) dev = d;
			`CHK("setPoint", sp[15:0], heldPidSetPoint)
			`CHK("measured", sp[15:0], heldPidMeasured)
			`CHK("deviation", dev[15:0], heldPidDeviation)
		end
		torqueParamMax = 16'h0FA0;
		torque_limit_input_method = TLIM_WORD;
		// last two passes take the single limit word; the unused word is out of range on purpose
		for (int i = 0; i < 10; i++) begin
			extended_setting_selection = exts[i%4];
			controlMode = i < 8 ? CTRL_TORQUE : CTRL_POSITION;
			torque_source_selection = i < 4 ? TSRC_3 : TSRC_5;
			w = i == 2 ? 4001 : i == 3 ? 4000 : $urandom_range(4000);
			pidDeviationOrTorqueCommand = i < 8 ? w[15:0] : ~w[15:0];
			torqueLimitFirstQuadrant = i < 8 ? ~w[15:0] : w[15:0];
			torqWrite(i[0]);
			if (w <= 4000) tq = w;
			`CHK("torqueRam", tq[15:0], torque_value_ram_param)
			`CHK("torqueEeprom", tq[15:0], torque_value_ram_eeprom_param)
			`CHK("torqueReply", w <= 4000, rep)
		end
		controlMode = CTRL_SPEED;
		extended_setting_selection = EXT_24;
		torque_source_selection = TSRC_3;
		for (int i = 0; i < 4; i++) begin
			w = i == 1 ? 40001 : i == 3 ? 40000 : $urandom_range(4000);
			q3 = $urandom_range(40000);
			q4 = i == 0 ? SKIP_CODE : i == 3 ? 16'h9C40 : 16'($urandom_range(40000));
			{torqueLimitFourthQuadrant, torqueLimitThirdQuadrant, torqueLimitSecondQuadrant} = {q4, q3, SKIP_CODE};
			torqueLimitFirstQuadrant = w[15:0];
			torqWrite(i != 2);
			if (w <= 40000 && i != 2) ql = {q4 == SKIP_CODE ? w[15:0] : q4, q3, w[15:0], w[15:0]};
			// quadrant range is wider than the torque param range
			if (w <= 4000 && i != 2) tq = w;
			`CHK("quadrants", ql, quadrantLimits)
			`CHK("quadReply", w <= 40000 && i != 2, rep)
			`CHK("torqueRam", tq[15:0], torque_value_ram_param)
		end
		for (int r = 0; r < 3; r++) begin
			lat = 4'(r * 3);
			expSlots = '{0};
			seen = {};
			baseInstructionSlot = $urandom;
			baseWriteData = $urandom;
			for (s = 1; s < 6; s++) begin
				c = (r == 2 || (r == 1 && $urandom_range(1) == 0)) ? SKIP_CODE : 16'($urandom_range(16'hFFFE));
				extraInstructionCodes[16*(s-1) +: 16] = c;
				extraInstructionWriteData[16*(s-1) +: 16] = $urandom;
				if (c != SKIP_CODE) expSlots.push_back(s);
			end
			instruction_execute_request = 1'b1;
			for (int k = 0; k < 200 && instruction_done_flag !== 1'b1; k++) tick(1);
			`CHK("done", 1'b1, instruction_done_flag)
			`CHK("slotCount", expSlots.size(), seen.size())
			foreach (expSlots[i]) begin
				s = expSlots[i];
				dw = s == 0 ? baseWriteData : extraInstructionWriteData[16*(s-1) +: 16];
				`CHK("slotOrder", expSlots[i], seen[i])
				`CHK("reply", {7'h00, dw[15]}, replyCodes[8*s +: 8])
				if (!dw[15]) `CHK("readData", ~dw, replyReadData[16*s +: 16])
			end
			instruction_execute_request = 1'b0;
			tick(2);
			`CHK("doneClear", 1'b0, instruction_done_flag)
		end
		for (int i = 0; i < 6; i++) begin
			signed_frequency_selection = i[0];
			fw = i < 2 ? 16'h8000 : 16'($urandom);
			setFrequency = fw;
			tick(2);
			neg = i[0] && fw[15];
			`CHK("reverse", neg[0], freqReverse)
			`CHK("magnitude", neg ? 16'(-fw) : fw, freqMagnitude)
		end
		conclude();
	end
endmodule : test_remote_word_command_handler
